// ===== common/intc_pkg.sv
// Purpose: Constants shared by the prioritised interrupt controller.
// Assumes: 32-bit APB, 128 sources, 16 priority levels.
// Notes:   Summary of operation follows.
`default_nettype none
package intc_pkg;
	localparam int SRC_COUNT = 128;
	localparam int LEVEL_W   = 4;
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 32;
	// Single registers, byte addresses
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_ENSET  = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_ENCLR  = 12'h010;
	// Word arrays, matched on upper address bits
	localparam logic [7:0] REGION_ENABLE = 8'h10; // 0x100..0x10C
	localparam logic [7:0] REGION_TYPE   = 8'h18; // 0x180..0x18C
	localparam logic [5:0] REGION_PRIO   = 6'h08; // 0x200..0x23C
	localparam logic [7:0] REGION_PEND   = 8'h28; // 0x280..0x28C
	// Reset values
	localparam logic                RST_GLOBAL_EN = 1'b0;
	localparam logic [LEVEL_W-1:0]  RST_MASK      = 4'h0;
	// Status word: idx [6:0], level [11:8], valid 12, fast 13
	localparam int STAT_VALID_BIT = 12;
	localparam int STAT_FAST_BIT  = 13;
	// Privileged access flag in pprot
	localparam int PROT_PRIV_BIT = 0;
endpackage
`default_nettype wire

// ===== src/prio_pick.sv
// Purpose: Pick the winning request by level, then by number.
// Assumes: Combinational; caller registers the result.
// Notes:   Linear scan; fine at the system clock rate.
`timescale 1ns/100ps
`default_nettype none
module prio_pick #(
	parameter int N  = 128,
	parameter int LW = 4,
	parameter int IW = $clog2(N)
) (
	input  wire logic [N-1:0]    req,
	input  wire logic [N*LW-1:0] levels,
	output logic                 valid,
	output logic [IW-1:0]        idx,
	output logic [LW-1:0]        level
);
	// Ascending scan with >= lets the higher number win a tie
	always_comb
	begin
		valid = 1'b0;
		idx   = '0;
		level = '0;
		for (int i = 0; i < N; i++)
		begin
			if (req[i] && (!valid || levels[i*LW +: LW] >= level))
			begin
				valid = 1'b1;
				idx   = IW'(i);
				level = levels[i*LW +: LW];
			end
		end
	end
endmodule // prio_pick
`default_nettype wire

// ===== src/prio_intc.sv
// Purpose: Prioritised interrupt controller with APB registers.
// Assumes: Sources synchronous to clk; level sensitive.
// Notes:   Requests and status lag the sources by one cycle.
`timescale 1ns/100ps
`default_nettype none
module prio_intc
	import intc_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [DATA_W-1:0]    pwdata,
	input  wire logic [2:0]           pprot,
	output logic      [DATA_W-1:0]    prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [SRC_COUNT-1:0] srcIn,
	output logic                      irqReq,
	output logic                      fiqReq
);
	localparam int IW = $clog2(SRC_COUNT);
	localparam int PW = SRC_COUNT*LEVEL_W;

	logic [SRC_COUNT-1:0] enable_ff;
	logic [SRC_COUNT-1:0] type_ff;
	logic [PW-1:0]        prio_ff;
	logic [LEVEL_W-1:0]   mask_ff;
	logic                 globalEn_ff;
	logic [DATA_W-1:0]    status_ff;
	logic [DATA_W-1:0]    prdata_ff;
	logic                 pready_ff;
	logic                 pslverr_ff;
	logic                 irqReq_ff;
	logic                 fiqReq_ff;

	logic [SRC_COUNT-1:0] nxt_enable;
	logic [SRC_COUNT-1:0] nxt_type;
	logic [PW-1:0]        nxt_prio;
	logic [DATA_W-1:0]    nxt_status;
	logic [SRC_COUNT-1:0] fastReq;
	logic [SRC_COUNT-1:0] normReq;
	logic                 normValid;
	logic [IW-1:0]        normIdx;
	logic [LEVEL_W-1:0]   normLvl;
	logic                 fastValid;
	logic [IW-1:0]        fastIdx;

	// Bus phase decode; a write lands only on the completing edge
	wire accessPh = psel & penable;
	wire respond  = accessPh & ~pready_ff;
	wire commit   = accessPh & pready_ff;
	wire privOk   = pprot[PROT_PRIV_BIT];
	wire wrOk     = commit & pwrite & privOk;

	// Address decode
	wire hitCtrl  = (paddr == OFS_CTRL);
	wire hitMask  = (paddr == OFS_MASK);
	wire hitStat  = (paddr == OFS_STATUS);
	wire hitEnset = (paddr == OFS_ENSET);
	wire hitEnclr = (paddr == OFS_ENCLR);
	wire hitEn    = (paddr[11:4] == REGION_ENABLE) & (paddr[1:0] == 2'h0);
	wire hitType  = (paddr[11:4] == REGION_TYPE) & (paddr[1:0] == 2'h0);
	wire hitPrio  = (paddr[11:6] == REGION_PRIO) & (paddr[1:0] == 2'h0);
	wire hitPend  = (paddr[11:4] == REGION_PEND) & (paddr[1:0] == 2'h0);
	wire mapped   = hitCtrl | hitMask | hitStat | hitEnset | hitEnclr
		| hitEn | hitType | hitPrio | hitPend;
	// User-mode or unmapped access is refused with an error
	wire errNow   = ~privOk | ~mapped;
	wire [1:0] word2 = paddr[3:2];
	wire [3:0] word4 = paddr[5:2];
	wire [6:0] wrNum = pwdata[6:0];

	// Read selection; set/clear-by-number words read as zero
	wire [SRC_COUNT-1:0] pendVec = srcIn & enable_ff;
	wire [DATA_W-1:0] rdData =
		hitCtrl ? {31'h0, globalEn_ff} :
		hitMask ? {28'h0, mask_ff} :
		hitStat ? status_ff :
		hitEn   ? enable_ff[{word2, 5'h00} +: DATA_W] :
		hitType ? type_ff[{word2, 5'h00} +: DATA_W] :
		hitPrio ? prio_ff[{word4, 5'h00} +: DATA_W] :
		hitPend ? pendVec[{word2, 5'h00} +: DATA_W] :
		32'h0;

	// Per-source register updates and request qualification
	genvar g;
	generate
		for (g = 0; g < SRC_COUNT; g++)
		begin : gSrc
			wire bitWr  = wrOk & hitEn & (word2 == 2'(g / 32));
			wire setNum = wrOk & hitEnset & (wrNum == 7'(g));
			wire clrNum = wrOk & hitEnclr & (wrNum == 7'(g));
			wire typWr  = wrOk & hitType & (word2 == 2'(g / 32));
			wire lvlWr  = wrOk & hitPrio & (word4 == 4'(g / 8));
			wire [LEVEL_W-1:0] lvl = prio_ff[g*LEVEL_W +: LEVEL_W];
			wire live = globalEn_ff & srcIn[g] & enable_ff[g];
			// Bitwise word or number registers both reach the enable
			assign nxt_enable[g] = bitWr ? pwdata[g % 32] :
				setNum ? 1'b1 : clrNum ? 1'b0 : enable_ff[g];
			assign nxt_type[g] = typWr ? pwdata[g % 32] : type_ff[g];
			// Sixteen 32-bit level words, eight sources each
			assign nxt_prio[g*LEVEL_W +: LEVEL_W] = lvlWr ?
				pwdata[(g % 8)*LEVEL_W +: LEVEL_W] : lvl;
			assign fastReq[g] = live & type_ff[g];
			// Strictly above the mask, so mask 15 blocks all normals
			assign normReq[g] = live & ~type_ff[g]
				& (lvl > mask_ff);
		end
	endgenerate

	// Normal winner by level and number
	prio_pick #(
		.N  (SRC_COUNT),
		.LW (LEVEL_W),
		.IW (IW)
	) uNormPick (
		.req    (normReq),
		.levels (prio_ff),
		.valid  (normValid),
		.idx    (normIdx),
		.level  (normLvl)
	);

	// Fast winner: all levels equal, so highest number wins
	prio_pick #(
		.N  (SRC_COUNT),
		.LW (LEVEL_W),
		.IW (IW)
	) uFastPick (
		.req    (fastReq),
		.levels ({PW{1'b0}}),
		.valid  (fastValid),
		.idx    (fastIdx),
		.level  ()
	);

	// Fast interrupts outrank every normal one
	assign nxt_status = fastValid ?
		{18'h0, 1'b1, 1'b1, 4'h0, 1'b0, fastIdx} :
		normValid ? {18'h0, 1'b0, 1'b1, normLvl, 1'b0, normIdx} :
		32'h0;

	// APB answer: one wait state, registered outputs
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end
		else
		begin
			pready_ff  <= respond;
			pslverr_ff <= respond & errNow;
			prdata_ff  <= (respond & ~errNow & ~pwrite) ? rdData : 32'h0;
		end
	end

	// Configuration state
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			enable_ff   <= '0;
			type_ff     <= '0;
			prio_ff     <= '0;
			mask_ff     <= RST_MASK;
			globalEn_ff <= RST_GLOBAL_EN;
		end
		else
		begin
			enable_ff <= nxt_enable;
			type_ff   <= nxt_type;
			prio_ff   <= nxt_prio;
			if (wrOk & hitMask)
				mask_ff <= pwdata[LEVEL_W-1:0];
			if (wrOk & hitCtrl)
				globalEn_ff <= pwdata[0];
		end
	end

	// Requests are levels: held as long as a qualifying source is
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			irqReq_ff <= 1'b0;
			fiqReq_ff <= 1'b0;
			status_ff <= 32'h0;
		end
		else
		begin
			irqReq_ff <= normValid;
			fiqReq_ff <= fastValid;
			status_ff <= nxt_status;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign irqReq  = irqReq_ff;
	assign fiqReq  = fiqReq_ff;

	// Checks on the design's own behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_fast_request_out: assert property (
		fiqReq_ff == $past(|(srcIn & enable_ff & type_ff) & globalEn_ff))
		else $error("fast request does not follow fast sources");

	a_normal_level_gate: assert property (
		(srcIn[5] & enable_ff[5] & ~type_ff[5] & globalEn_ff
			& (prio_ff[5*LEVEL_W +: LEVEL_W] > mask_ff)) |=> irqReq_ff)
		else $error("qualifying source 5 did not raise normal request");

	// Highest number as a fast source must win outright
	a_top_source_seen: assert property (
		(srcIn[SRC_COUNT-1] & enable_ff[SRC_COUNT-1]
			& type_ff[SRC_COUNT-1] & globalEn_ff)
		|=> fiqReq_ff && status_ff[IW-1:0] == IW'(SRC_COUNT-1))
		else $error("highest source number lost");

	a_user_refused: assert property (
		(respond & ~privOk) |=> pslverr_ff && pready_ff && prdata_ff == 0)
		else $error("user mode access not refused");

	a_user_no_write: assert property (
		(commit & ~privOk) |=> $stable(mask_ff) && $stable(enable_ff)
			&& $stable(globalEn_ff))
		else $error("user mode write changed state");

	a_fast_over_normal: assert property (
		(fastValid & normValid) |=> status_ff[STAT_FAST_BIT]
			&& status_ff[STAT_VALID_BIT] && irqReq_ff && fiqReq_ff)
		else $error("normal ranked above fast");

	a_winner_level: assert property (
		normValid |-> normReq[normIdx]
			&& prio_ff[normIdx*LEVEL_W +: LEVEL_W] == normLvl
			&& (normIdx == 7'h7F || !normReq[normIdx + 7'h01]
			|| prio_ff[(normIdx+7'h01)*LEVEL_W +: LEVEL_W] < normLvl))
		else $error("normal winner level or tie break wrong");

	a_enset_number: assert property (
		(wrOk & hitEnset) |=> enable_ff[$past(wrNum)])
		else $error("enable by number did not set");

	a_enclr_number: assert property (
		(wrOk & hitEnclr) |=> !enable_ff[$past(wrNum)])
		else $error("disable by number did not clear");

	a_prio_store: assert property (
		(wrOk & hitPrio) |=> prio_ff[{$past(word4), 5'h00} +: DATA_W]
			== $past(pwdata))
		else $error("priority word not stored");

	a_mask_store: assert property (
		(wrOk & hitMask) |=> mask_ff == $past(pwdata[LEVEL_W-1:0]))
		else $error("mask write not stored");

	// A full mask leaves no level above it, whatever the sources do
	a_mask_full_block: assert property (
		(&mask_ff) |=> !irqReq_ff)
		else $error("normal request passed a full mask");

	// Global enable off must silence both request lines
	a_global_off_quiet: assert property (
		!globalEn_ff |=> !irqReq_ff && !fiqReq_ff)
		else $error("request raised with global enable off");

	a_enable_word: assert property (
		(wrOk & hitEn) |=> enable_ff[{$past(word2), 5'h00} +: DATA_W]
			== $past(pwdata))
		else $error("enable word not stored");

	a_type_word: assert property (
		(wrOk & hitType) |=> type_ff[{$past(word2), 5'h00} +: DATA_W]
			== $past(pwdata))
		else $error("type word not stored");

	// Software reads the status word to find the line it must serve
	a_status_fast_flag: assert property (
		fiqReq_ff == status_ff[STAT_FAST_BIT]
			&& (irqReq_ff | fiqReq_ff) == status_ff[STAT_VALID_BIT])
		else $error("status flags disagree with requests");

	a_ready_pulse: assert property (
		respond |=> pready_ff ##1 !pready_ff)
		else $error("ready not a single cycle");

	c_fast_and_normal: cover property (fastValid & normValid);
	c_level_tie: cover property (normValid & (normIdx != 7'h00)
		& normReq[normIdx - 7'h01]
		& (prio_ff[(normIdx-7'h01)*LEVEL_W +: LEVEL_W] == normLvl));
	c_user_access: cover property (respond & ~privOk);
	c_masked_out: cover property (|(srcIn & enable_ff & ~type_ff)
		& ~normValid & globalEn_ff);
	c_top_fast: cover property (fastValid & (fastIdx == IW'(SRC_COUNT-1)));

endmodule // prio_intc
`default_nettype wire

// ===== verif/core_model.sv
// Purpose: Behavioural core that counts request entries.
// Assumes: Requests are active-high levels synchronous to clk.
// Notes:   Never acknowledges; the controller holds no handshake.
`timescale 1ns/100ps
`default_nettype none
module core_model (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       irqReq,
	input  wire logic       fiqReq,
	output logic      [7:0] irqSeen,
	output logic      [7:0] fiqSeen
);
	logic [1:0] last_ff;
	logic [7:0] irqCnt_ff;
	logic [7:0] fiqCnt_ff;
	// A rising level is one exception entry; a held level is not re-taken
	always_ff @(posedge clk)
	begin
		last_ff <= srst ? 2'h0 : {fiqReq, irqReq};
		if (srst)
		begin
			irqCnt_ff <= 8'h00;
			fiqCnt_ff <= 8'h00;
		end
		else
		begin
			if (irqReq && !last_ff[0]) irqCnt_ff <= irqCnt_ff + 8'h01;
			if (fiqReq && !last_ff[1]) fiqCnt_ff <= fiqCnt_ff + 8'h01;
		end
	end
	assign irqSeen = irqCnt_ff;
	assign fiqSeen = fiqCnt_ff;
endmodule // core_model
`default_nettype wire

// ===== verif/test_prio_intc.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: APB answers with one wait state; requests lag by one edge.
// Notes:   All accesses are privileged unless a test says otherwise.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin samplesChecked++; if ((got) !== (exp)) \
	begin nFail++; $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module test_prio_intc;
	import intc_pkg::*;
	logic                 clk = 1'b0;
	logic                 srst = 1'b1;
	logic                 psel = 1'b0;
	logic                 penable = 1'b0;
	logic                 pwrite = 1'b0;
	logic [ADDR_W-1:0]    paddr = 12'h000;
	logic [DATA_W-1:0]    pwdata = 32'h0;
	logic [2:0]           pprot = 3'h1;
	logic [DATA_W-1:0]    prdata;
	logic                 pready;
	logic                 pslverr;
	logic [SRC_COUNT-1:0] srcIn = '0;
	logic                 irqReq;
	logic                 fiqReq;
	logic [7:0]           fiqSeen;
	logic [7:0]           irqSeen;
	logic [DATA_W-1:0]    rdv;
	logic                 erv;
	int                   nFail = 0;
	int                   samplesChecked = 0;
	prio_intc u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .srcIn(srcIn),
		.irqReq(irqReq), .fiqReq(fiqReq));
	core_model u_core (.clk(clk), .srst(srst), .irqReq(irqReq),
		.fiqReq(fiqReq), .irqSeen(irqSeen), .fiqSeen(fiqSeen));
	// 10 MHz system clock
	initial
	begin
		forever #50 clk = ~clk;
	end
	task automatic closeOut();
		$display("Checks %0d, mismatches %0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [2:0] pr);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pprot <= pr;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		rdv = prdata;
		erv = pslverr;
		if (n >= 20) nFail++;
		if (n >= 20) closeOut();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 3'h1);
		`CHK("write error", 1'b0, erv)
	endtask
	task automatic rd(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0, 3'h1);
		`CHK(nm, e, rdv)
	endtask
	// Requests settle one edge after their cause
	task automatic req(input string nm, input logic i, input logic f);
		repeat (2) @(posedge clk);
		`CHK(nm, {i, f}, {irqReq, fiqReq})
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd("ctrl reset", OFS_CTRL, 32'h0);
		rd("mask reset", OFS_MASK, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h1, 3'h0);
		`CHK("user write refused", 1'b1, erv)
		rd("ctrl kept", OFS_CTRL, 32'h0);
		apb(1'b0, 12'hFFC, 32'h0, 3'h1);
		`CHK("unmapped refused", 1'b1, erv)
		$display("Test access done");
		wr(OFS_CTRL, 32'h1);
		wr(OFS_ENSET, 32'h5);
		wr(12'h200, 32'h0030_0000);
		wr(OFS_MASK, 32'h2);
		srcIn[5] <= 1'b1;
		req("irq above mask", 1'b1, 1'b0);
		rd("status src5", OFS_STATUS, 32'h0000_1305);
		wr(OFS_MASK, 32'h3);
		req("level equal mask", 1'b0, 1'b0);
		wr(OFS_MASK, 32'h2);
		wr(12'h200, 32'h0330_0000);
		wr(OFS_ENSET, 32'h6);
		srcIn[6] <= 1'b1;
		rd("tie high number", OFS_STATUS, 32'h0000_1306);
		rd("pending", 12'h280, 32'h0000_0060);
		wr(OFS_CTRL, 32'h0);
		req("global off", 1'b0, 1'b0);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_MASK, 32'h0);
		wr(12'h10C, 32'h8000_0000);
		wr(12'h23C, 32'h1000_0000);
		srcIn[127] <= 1'b1;
		rd("level beats number", OFS_STATUS, 32'h0000_1306);
		wr(12'h23C, 32'hF000_0000);
		rd("top level wins", OFS_STATUS, 32'h0000_1F7F);
		wr(OFS_MASK, 32'hF);
		req("mask blocks all", 1'b0, 1'b0);
		$display("Test normal done");
		wr(12'h18C, 32'h8000_0000);
		req("fast past mask", 1'b0, 1'b1);
		rd("fast first", OFS_STATUS, 32'h0000_307F);
		wr(OFS_MASK, 32'h0);
		req("fast and normal", 1'b1, 1'b1);
		rd("fast over normal", OFS_STATUS, 32'h0000_307F);
		wr(OFS_MASK, 32'hF);
		wr(OFS_ENCLR, 32'h7F);
		req("fast disabled", 1'b0, 1'b0);
		wr(OFS_MASK, 32'h2);
		req("irq held", 1'b1, 1'b0);
		srcIn[6] <= 1'b0;
		srcIn[5] <= 1'b0;
		req("irq drops", 1'b0, 1'b0);
		wr(12'h100, 32'h0);
		rd("enables cleared", 12'h100, 32'h0);
		`CHK("core fiq entries", 8'h01, fiqSeen)
		`CHK("core irq entries", 8'h05, irqSeen)
		$display("Test fast done");
		closeOut();
	end
endmodule // test_prio_intc
`undef CHK
`default_nettype wire
